// File: core/cicr_pkg.sv
// Purpose: Constants and types for the cursor/ink colour register bank
// Assumes: AHB-Lite slave, 32-bit data, one register per aligned word
// Notes: Printed offsets are not word multiples, so byte address is index times four
// Functional notes
// - Colour 0 green is six bits, register bits 5..0.
// - Colour 0 red is five bits, register bits 4..0.
// - Colour 1 blue is five bits, register bits 4..0.
// - Colour 1 green is six bits, register bits 5..0.
// - Colour 1 red is five bits, register bits 4..0.
// - Colour 1 blue, green, red sit at consecutive indices from 08Ah, read/write.
// - Programmed threshold sets the FIFO high threshold for the overlay fetch.
// - Threshold of zero selects a hardware-chosen threshold.
// - Colour 0 blue is five bits, register bits 4..0.
package cicr_pkg;
    // ------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_C0_BLUE = 8'h86;
    localparam logic [7:0] IDX_C0_GREEN = 8'h87;
    localparam logic [7:0] IDX_C0_RED = 8'h88;
    localparam logic [7:0] IDX_C1_BLUE = 8'h8A;
    localparam logic [7:0] IDX_C1_GREEN = 8'h8B;
    localparam logic [7:0] IDX_C1_RED = 8'h8C;
    localparam logic [7:0] IDX_FIFO_THR = 8'h8E;
    localparam int IDX_LSB = 2;
    localparam int IDX_W = 8;

    // ------------------------------------------------------------
    // Field widths and reset values
    // ------------------------------------------------------------
    localparam int BLUE_W = 5;
    localparam int GREEN_W = 6;
    localparam int RED_W = 5;
    localparam int THR_W = 6;
    localparam logic [THR_W-1:0] THR_AUTO_CODE = 6'h00;
    localparam logic [THR_W-1:0] THR_AUTO_VALUE = 6'h20;
    localparam logic [4:0] BLUE_RST = 5'h00;
    localparam logic [5:0] GREEN_RST = 6'h00;
    localparam logic [4:0] RED_RST = 5'h00;
    localparam logic [5:0] THR_RST = 6'h00;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic HRESP_OKAY = 1'b0;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [RED_W-1:0] red;
        logic [GREEN_W-1:0] green;
        logic [BLUE_W-1:0] blue;
    } cicr_rgb565_t;

    typedef struct packed {
        logic write;
        logic [IDX_W-1:0] idx;
    } cicr_req_t;
endpackage : cicr_pkg

// File: core/cicr_regs.sv
// Purpose: AHB-Lite register bank for the two cursor/ink colours and threshold
// Assumes: Single-word transfers, zero wait states, OKAY always
// Notes: Unmapped addresses read zero and drop writes
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module cicr_regs
    import cicr_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output cicr_rgb565_t color0,
    output cicr_rgb565_t color1,
    output logic [THR_W-1:0] fifo_threshold
);
    // ------------------------------------------------------------
    // Address phase capture
    // ------------------------------------------------------------
    cicr_req_t req_ff;
    cicr_req_t nxt_req;
    logic pend_ff;
    logic nxt_pend;
    logic addr_valid;

    assign addr_valid = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

    always_comb begin
        nxt_pend = addr_valid;
        nxt_req.write = hwrite;
        nxt_req.idx = haddr[IDX_LSB +: IDX_W];
        if (!addr_valid) begin
            nxt_req = req_ff;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_ff <= '0;
            pend_ff <= 1'b0;
        end else begin
            req_ff <= nxt_req;
            pend_ff <= nxt_pend;
        end
    end

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    cicr_rgb565_t c0_ff;
    cicr_rgb565_t c1_ff;
    cicr_rgb565_t nxt_c0;
    cicr_rgb565_t nxt_c1;
    logic [THR_W-1:0] thr_ff;
    logic [THR_W-1:0] nxt_thr;
    logic wr_en;

    assign wr_en = pend_ff && req_ff.write;

    always_comb begin
        nxt_c0 = c0_ff;
        nxt_c1 = c1_ff;
        nxt_thr = thr_ff;
        // Only the defined low bits are stored; upper bits are dropped
        if (wr_en) begin
            unique case (req_ff.idx)
                IDX_C0_BLUE: nxt_c0.blue = hwdata[BLUE_W-1:0];
                IDX_C0_GREEN: nxt_c0.green = hwdata[GREEN_W-1:0];
                IDX_C0_RED: nxt_c0.red = hwdata[RED_W-1:0];
                IDX_C1_BLUE: nxt_c1.blue = hwdata[BLUE_W-1:0];
                IDX_C1_GREEN: nxt_c1.green = hwdata[GREEN_W-1:0];
                IDX_C1_RED: nxt_c1.red = hwdata[RED_W-1:0];
                IDX_FIFO_THR: nxt_thr = hwdata[THR_W-1:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            c0_ff <= '{red: RED_RST, green: GREEN_RST, blue: BLUE_RST};
            c1_ff <= '{red: RED_RST, green: GREEN_RST, blue: BLUE_RST};
            thr_ff <= THR_RST;
        end else begin
            c0_ff <= nxt_c0;
            c1_ff <= nxt_c1;
            thr_ff <= nxt_thr;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Read data is registered at the address phase so hrdata is a flop
    logic [31:0] rd_ff;
    logic [31:0] nxt_rd;

    function automatic logic [31:0] read_mux(
        input logic [IDX_W-1:0] idx,
        input cicr_rgb565_t c0,
        input cicr_rgb565_t c1,
        input logic [THR_W-1:0] thr
    );
        logic [31:0] d;
        d = '0;
        unique case (idx)
            IDX_C0_BLUE: d[BLUE_W-1:0] = c0.blue;
            IDX_C0_GREEN: d[GREEN_W-1:0] = c0.green;
            IDX_C0_RED: d[RED_W-1:0] = c0.red;
            IDX_C1_BLUE: d[BLUE_W-1:0] = c1.blue;
            IDX_C1_GREEN: d[GREEN_W-1:0] = c1.green;
            IDX_C1_RED: d[RED_W-1:0] = c1.red;
            IDX_FIFO_THR: d[THR_W-1:0] = thr;
            default: d = '0;
        endcase
        return d;
    endfunction : read_mux

    always_comb begin
        nxt_rd = '0;
        // Back-to-back write then read of same word bypasses the store
        if (addr_valid && !hwrite) begin
            nxt_rd = read_mux(haddr[IDX_LSB +: IDX_W], nxt_c0, nxt_c1, nxt_thr);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_ff <= '0;
        end else begin
            rd_ff <= nxt_rd;
        end
    end

    // ------------------------------------------------------------
    // Overlay outputs
    // ------------------------------------------------------------
    logic [THR_W-1:0] thr_eff;

    cicr_thr_sel u_thr_sel (
        .hclk(hclk),
        .hresetn(hresetn),
        .thr_prog(thr_ff),
        .thr_eff(thr_eff)
    );

    assign hrdata = rd_ff;
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;
    assign color0 = c0_ff;
    assign color1 = c1_ff;
    assign fifo_threshold = thr_eff;
endmodule : cicr_regs

// File: core/cicr_thr_sel.sv
// Purpose: Picks the effective FIFO high threshold for the overlay fetch
// Assumes: Programmed value from the register bank, same clock
// Notes: Output registered
`timescale 1ns/100ps
module cicr_thr_sel
    import cicr_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [THR_W-1:0] thr_prog,
    output logic [THR_W-1:0] thr_eff
);
    logic [THR_W-1:0] thr_ff;
    logic [THR_W-1:0] nxt_thr;

    always_comb begin
        if (thr_prog == THR_AUTO_CODE) begin
            nxt_thr = THR_AUTO_VALUE;
        end else begin
            nxt_thr = thr_prog;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            thr_ff <= THR_AUTO_VALUE;
        end else begin
            thr_ff <= nxt_thr;
        end
    end

    assign thr_eff = thr_ff;
endmodule : cicr_thr_sel

// File: sim/cicr_chk.sv
// Purpose: Bus answer and output timing checks for the colour register bank
// Assumes: One clock, zero wait states, writes land at the end of the data phase
// Notes: Bound onto cicr_regs by the statement after the module
`timescale 1ns/100ps
module cicr_chk
    import cicr_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire cicr_rgb565_t color0,
    input wire cicr_rgb565_t color1,
    input wire logic [THR_W-1:0] fifo_threshold
);
    logic wr_ff, rd_ff;
    logic [7:0] idx_ff;
    wire tk = hsel & hready & htrans[1];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
        end else begin
            wr_ff <= tk & hwrite;
            rd_ff <= tk & ~hwrite;
        end
    end
    always_ff @(posedge hclk) idx_ff <= haddr[9:2];
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_answer_okay: assert property (hreadyout && hresp == HRESP_OKAY)
        else $error("bus answer not zero-wait okay");
    a_c0_blue: assert property (wr_ff && idx_ff == IDX_C0_BLUE
        |=> color0.blue == $past(hwdata[4:0])) else $error("colour 0 blue wrong");
    a_c0_red: assert property (wr_ff && idx_ff == IDX_C0_RED
        |=> color0.red == $past(hwdata[4:0])) else $error("colour 0 red wrong");
    a_c1_blue: assert property (wr_ff && idx_ff == IDX_C1_BLUE
        |=> color1.blue == $past(hwdata[4:0])) else $error("colour 1 blue wrong");
    a_rd_narrow: assert property (rd_ff && (idx_ff == IDX_C0_BLUE || idx_ff == IDX_C0_RED
        || idx_ff == IDX_C1_BLUE || idx_ff == IDX_C1_RED) |-> hrdata[31:5] == 27'h0)
        else $error("five-bit read has upper bits set");
    a_c0_green: assert property (wr_ff && idx_ff == IDX_C0_GREEN
        |=> color0.green == $past(hwdata[5:0])) else $error("colour 0 green wrong");
    a_c1_green: assert property (wr_ff && idx_ff == IDX_C1_GREEN
        |=> color1.green == $past(hwdata[5:0])) else $error("colour 1 green wrong");
    a_c1_red: assert property (wr_ff && idx_ff == IDX_C1_RED
        |=> color1.red == $past(hwdata[4:0])) else $error("colour 1 red wrong");
    a_thr_prog: assert property (wr_ff && idx_ff == IDX_FIFO_THR && hwdata[5:0] != 6'h00
        |=> ##1 fifo_threshold == $past(hwdata[5:0], 2)) else $error("threshold wrong");
    a_thr_auto: assert property (wr_ff && idx_ff == IDX_FIFO_THR && hwdata[5:0] == 6'h00
        |=> ##1 fifo_threshold == THR_AUTO_VALUE) else $error("auto threshold wrong");
    a_rd_upper: assert property (rd_ff && idx_ff[7:4] == 4'h8 |-> hrdata[31:6] == 26'h0)
        else $error("upper read bits not zero");
    a_colour_hold: assert property (!wr_ff |=> $stable(color0) && $stable(color1))
        else $error("colour changed without write");
    cover property (wr_ff && idx_ff == IDX_FIFO_THR);
    cover property (rd_ff && idx_ff == IDX_C1_RED);
    // Master never pipelines, so a read data phase trails a write by two
    cover property (wr_ff ##2 rd_ff);
endmodule : cicr_chk
bind cicr_regs cicr_chk u_chk (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hwdata(hwdata),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .color0(color0),
    .color1(color1),
    .fifo_threshold(fifo_threshold)
);

// File: sim/cicr_regs_tb.sv
// Purpose: Register access tests for the colour register bank
// Assumes: Zero wait slave, master drives by non-blocking assignment at rising edges
// Notes: Read data is the value settled before the edge that ends the data phase
`timescale 1ns/100ps
module cicr_regs_tb
    import cicr_pkg::*;
;
    logic hclk, hresetn, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd_q, r;
    logic [1:0] htrans;
    cicr_rgb565_t color0, color1;
    logic [THR_W-1:0] fifo_threshold;
    int num_errors = 0;
    int n_checks = 0;
    logic [7:0] idx_tab [7] = '{IDX_C0_BLUE, IDX_C0_GREEN, IDX_C0_RED, IDX_C1_BLUE,
        IDX_C1_GREEN, IDX_C1_RED, IDX_FIFO_THR};
    logic [31:0] msk_tab [7] = '{32'h1F, 32'h3F, 32'h1F, 32'h1F, 32'h3F, 32'h1F, 32'h3F};
    cicr_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .color0(color0), .color1(color1), .fifo_threshold(fifo_threshold));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // Settled value just before each rising edge, avoids an edge race
    always @(negedge hclk) rd_q = hrdata;
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task wait_rdy;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask : wait_rdy
    task xfer(input logic w, input logic [7:0] i, input logic [31:0] d);
        haddr <= {22'h0, i, 2'h0};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        r = rd_q;
    endtask : xfer
    task outs(input logic [15:0] e0, input logic [15:0] e1, input logic [5:0] et);
        @(negedge hclk);
        @(negedge hclk);
        chk("color0", {16'h0, color0}, {16'h0, e0});
        chk("color1", {16'h0, color1}, {16'h0, e1});
        chk("thr", {26'h0, fifo_threshold}, {26'h0, et});
        @(posedge hclk);
    endtask : outs
    task final_report;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    initial begin
        #50000;
        num_errors++;
        final_report;
    end
    initial begin
        hresetn = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        outs(16'h0, 16'h0, THR_AUTO_VALUE);
        // Back-to-back all-ones writes show which bits really exist
        for (int i = 0; i < 7; i++) xfer(1'b1, idx_tab[i], 32'hFFFFFFFF);
        for (int i = 0; i < 7; i++) begin
            xfer(1'b0, idx_tab[i], 32'h0);
            chk("mask", r, msk_tab[i]);
        end
        outs(16'hFFFF, 16'hFFFF, 6'h3F);
        for (int i = 0; i < 7; i++) begin
            xfer(1'b1, idx_tab[i], 32'hA5A5A5A5);
            xfer(1'b0, idx_tab[i], 32'h0);
            chk("readback", r, 32'hA5A5A5A5 & msk_tab[i]);
        end
        outs({5'h05, 6'h25, 5'h05}, {5'h05, 6'h25, 5'h05}, 6'h25);
        xfer(1'b1, IDX_FIFO_THR, 32'hFFFFFFC0);
        xfer(1'b0, IDX_FIFO_THR, 32'h0);
        chk("thr zero", r, 32'h0);
        outs({5'h05, 6'h25, 5'h05}, {5'h05, 6'h25, 5'h05}, THR_AUTO_VALUE);
        xfer(1'b1, 8'h89, 32'hFFFFFFFF);
        xfer(1'b0, 8'h89, 32'h0);
        chk("unmapped", r, 32'h0);
        final_report;
    end
endmodule : cicr_regs_tb
